// *** pkg/tcs_params.svh ***
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH
`define TCS_ADDR_CTRL 8'h12
`define TCS_ADDR_FLAGS 8'h13
`define TCS_ADDR_CAP_HI 8'h14
`define TCS_ADDR_CAP_LO 8'h15
`define TCS_ADDR_CMP_HI 8'h16
`define TCS_ADDR_CMP_LO 8'h17
`define TCS_ADDR_CNT_HI 8'h18
`define TCS_ADDR_CNT_LO 8'h19
`define TCS_ADDR_ALT_HI 8'h1A
`define TCS_ADDR_ALT_LO 8'h1B
`define TCS_BIT_CAP_FLAG 7
`define TCS_BIT_CMP_FLAG 6
`define TCS_BIT_OVF_FLAG 5
`define TCS_BIT_CAP_IE 7
`define TCS_BIT_CMP_IE 6
`define TCS_BIT_OVF_IE 5
`define TCS_BIT_EDGE 1
`define TCS_BIT_OLV 0
`define TCS_CNT_RESET 16'hFFFC
`define TCS_CTRL_RESET 8'h00
`define TCS_PRESCALE 4
`endif

// *** pkg/tcs_pkg.sv ***
package tcs_pkg;
   // timer state inside one counter step; counter advances on t11
   typedef enum logic [3:0] {
      TCS_T00 = 4'b0001,
      TCS_T01 = 4'b0010,
      TCS_T10 = 4'b0100,
      TCS_T11 = 4'b1000
   } tcs_phase_e;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tcs_bus_s;
   typedef struct packed {
      logic cap;
      logic cmp;
      logic ovf;
   } tcs_flags_s;
endpackage : tcs_pkg

// *** verilog/tcs_edge_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module tcs_edge_sync
   import tcs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic pin,
   input wire logic rising_sel,
   output logic edge_seen
);
   logic meta;
   logic sync;
   logic prev;
   wire rise = sync & ~prev;
   wire fall = ~sync & prev;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end
   assign edge_seen = rising_sel ? rise : fall;
endmodule : tcs_edge_sync
`default_nettype wire

// *** verilog/tcs_timer.sv ***
// What this block does
// RULE1: flags in bits 7,6,5; low bits zero
// RULE2: capture edge sets capture flag, clear sequence
// RULE3: compare match sets flag, clear sequence
// RULE4: rollover sets overflow flag, clear sequence
// RULE5: software reads alternate counter for timing
// RULE6: 16-bit read-only capture latches counter
// RULE7: captured value is count plus one
// RULE8: every capture overwrites, flag notwithstanding
// RULE9: high-byte read blocks capture until low; code still loads a stop-time capture at wake while blocked
// RULE10: capture holding bits not reset
// RULE11: continual compare loads output level bit
// RULE12: high-byte write suspends compare until low
// RULE13: output level moves on every match
// RULE14: compare bytes read/write, never reset
// RULE15: software writes high, reads flags, writes low
// RULE16: wait mode keeps counting, interrupts wake
// RULE17: stop halts counter; reset presets it
// RULE18: stop-time capture edge armed, shown at wake
// RULE19: reset touches only counter and control; code also resets read-buffer valid bits, irq, rdata and stop_cap_seen
// RULE20: capture flag appears at following t11
// RULE21: compare only at t01, flag at t11
// RULE22: overflow at t11; flags read then counter low
// RULE23: counter steps every four bus clocks
// RULE24: edge select one rising, zero falling
// RULE25: alternate copy never clears overflow
// RULE26: counter presets to FFFC, read-only
// RULE27: capture pin synchronised through two stages
`timescale 1ns/10ps
`default_nettype none
`include "tcs_params.svh"
module tcs_timer
   import tcs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire tcs_bus_s bus,
   input wire logic stop_mode,
   input wire logic capture_pin,
   output logic [7:0] rdata,
   output logic compare_pin,
   output logic irq,
   output logic [15:0] count
);
   tcs_phase_e phase;
   logic [7:0] ctrl;
   tcs_flags_s flags;
   tcs_flags_s armed;
   logic [15:0] capture_value;
   logic [15:0] compare_value;
   logic [15:0] cnt_hold;
   logic cnt_buf_valid;
   logic alt_buf_valid;
   logic [7:0] cnt_lo_buf;
   logic cap_block;
   logic cmp_block;
   logic cap_pend;
   logic cmp_pend;
   logic stop_edge;
   logic stop_cap_seen;
   logic [15:0] stop_cap_val;
   // count seen when the pin was first sampled, delayed to line up with the synchroniser
   logic [15:0] cnt_d1;
   logic [15:0] cnt_d2;

   wire run = ~stop_mode;
   wire rd_flags = (bus.rd | bus.wr) && bus.addr == `TCS_ADDR_FLAGS;
   wire rd_cap_hi = bus.rd && bus.addr == `TCS_ADDR_CAP_HI;
   wire rd_cap_lo = bus.rd && bus.addr == `TCS_ADDR_CAP_LO;
   wire rd_cmp_lo = bus.rd && bus.addr == `TCS_ADDR_CMP_LO;
   wire wr_cmp_hi = bus.wr && bus.addr == `TCS_ADDR_CMP_HI;
   wire wr_cmp_lo = bus.wr && bus.addr == `TCS_ADDR_CMP_LO;
   wire wr_ctrl = bus.wr && bus.addr == `TCS_ADDR_CTRL;
   wire rd_cnt_hi = bus.rd && bus.addr == `TCS_ADDR_CNT_HI;
   wire rd_cnt_lo = bus.rd && bus.addr == `TCS_ADDR_CNT_LO;
   wire rd_alt_hi = bus.rd && bus.addr == `TCS_ADDR_ALT_HI;
   wire rd_alt_lo = bus.rd && bus.addr == `TCS_ADDR_ALT_LO;
   wire at_t01 = phase == TCS_T01;
   wire at_t11 = phase == TCS_T11;
   wire edge_seen;
   wire cap_event = edge_seen & run & ~cap_block; // RULE9
   // edge in the window t11..t10 shows its flag at the next t11
   wire set_cap = run & at_t11 & cap_pend; // RULE20
   wire set_cmp = run & at_t11 & cmp_pend; // RULE21
   wire set_ovf = run & at_t11 & (count == 16'hFFFF); // RULE22
   wire clr_cap = armed.cap & rd_cap_lo; // RULE2
   wire clr_cmp = armed.cmp & rd_cmp_lo; // RULE3
   wire clr_ovf = armed.ovf & rd_cnt_lo; // RULE4 RULE25
   wire [15:0] count_next = count + 16'h0001;
   wire [15:0] cap_count = cnt_d2 + 16'h0001; // RULE7
   wire match = at_t01 & run & ~cmp_block & (compare_value == count); // RULE11 RULE21
   wire [7:0] flags_byte = {flags.cap, flags.cmp, flags.ovf, 5'h00}; // RULE1
   wire any_irq = (flags.cap & ctrl[`TCS_BIT_CAP_IE]) | (flags.cmp & ctrl[`TCS_BIT_CMP_IE])
                  | (flags.ovf & ctrl[`TCS_BIT_OVF_IE]); // RULE16
   logic [7:0] next_rdata;

   tcs_edge_sync u_sync (
      .mclk(mclk),
      .rst(rst),
      .pin(capture_pin), // RULE27
      .rising_sel(ctrl[`TCS_BIT_EDGE]), // RULE24
      .edge_seen(edge_seen)
   );

   always_comb begin
      unique case (bus.addr)
         `TCS_ADDR_CTRL: next_rdata = ctrl;
         `TCS_ADDR_FLAGS: next_rdata = flags_byte;
         `TCS_ADDR_CAP_HI: next_rdata = capture_value[15:8]; // RULE6
         `TCS_ADDR_CAP_LO: next_rdata = capture_value[7:0];
         `TCS_ADDR_CMP_HI: next_rdata = compare_value[15:8]; // RULE14
         `TCS_ADDR_CMP_LO: next_rdata = compare_value[7:0];
         `TCS_ADDR_CNT_HI: next_rdata = count[15:8];
         `TCS_ADDR_CNT_LO: next_rdata = cnt_buf_valid ? cnt_lo_buf : count[7:0];
         `TCS_ADDR_ALT_HI: next_rdata = count[15:8];
         `TCS_ADDR_ALT_LO: next_rdata = alt_buf_valid ? cnt_lo_buf : count[7:0];
         default: next_rdata = 8'h00;
      endcase
   end

   // prescaler phase and counter; reset presets the count
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         phase <= TCS_T00;
         count <= `TCS_CNT_RESET; // RULE26 RULE17
      end else if (run) begin // RULE17 RULE16
         unique case (phase)
            TCS_T00: phase <= TCS_T01;
            TCS_T01: phase <= TCS_T10;
            TCS_T10: phase <= TCS_T11;
            TCS_T11: begin
               phase <= TCS_T00;
               count <= count_next; // RULE23
            end
         endcase
      end
   end

   // control register; reset also clears the read-buffer valid bits, irq, rdata and stop_cap_seen
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl <= `TCS_CTRL_RESET; // RULE19
      end else if (wr_ctrl) begin
         ctrl <= {bus.wdata[7:5], 3'b000, bus.wdata[1:0]};
      end
   end

   // counter low-byte buffer for coherent two-byte reads
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_buf_valid <= 1'b0;
         alt_buf_valid <= 1'b0;
         irq <= 1'b0;
         rdata <= 8'h00;
      end else begin
         irq <= any_irq;
         if (bus.rd)
            rdata <= next_rdata;
         if (rd_cnt_hi)
            cnt_buf_valid <= 1'b1;
         else if (rd_cnt_lo)
            cnt_buf_valid <= 1'b0;
         if (rd_alt_hi)
            alt_buf_valid <= 1'b1;
         else if (rd_alt_lo)
            alt_buf_valid <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if ((rd_cnt_hi & ~cnt_buf_valid) | (rd_alt_hi & ~alt_buf_valid))
         cnt_lo_buf <= count[7:0];
   end

   // without this delay the latched count would run up to two clocks late
   always_ff @(posedge mclk) begin
      cnt_d1 <= count;
      cnt_d2 <= cnt_d1;
   end

   // flag, capture and compare state is deliberately outside reset, save stop_cap_seen
   always_ff @(posedge mclk) begin
      if (rst) begin
         stop_cap_seen <= 1'b0; // RULE18
      end else begin
         if (stop_mode & edge_seen & ~stop_cap_seen) begin
            stop_cap_seen <= 1'b1; // RULE18
            stop_cap_val <= cap_count;
         end else if (run)
            stop_cap_seen <= 1'b0;
         if (cap_event) begin
            capture_value <= cap_count; // RULE7 RULE8
            cap_pend <= 1'b1;
         end else if (run & stop_cap_seen) begin
            capture_value <= stop_cap_val; // RULE18
            cap_pend <= 1'b1;
         end else if (set_cap)
            cap_pend <= 1'b0;
         if (rd_cap_hi)
            cap_block <= 1'b1; // RULE9
         else if (rd_cap_lo)
            cap_block <= 1'b0;
         if (wr_cmp_hi) begin
            compare_value[15:8] <= bus.wdata; // RULE12
            cmp_block <= 1'b1;
         end
         if (wr_cmp_lo) begin
            compare_value[7:0] <= bus.wdata;
            cmp_block <= 1'b0;
         end
         if (match) begin
            cmp_pend <= 1'b1;
            compare_pin <= ctrl[`TCS_BIT_OLV]; // RULE13
         end else if (set_cmp)
            cmp_pend <= 1'b0;
         // set wins over a clear landing in the same cycle
         flags.cap <= set_cap | (flags.cap & ~clr_cap);
         flags.cmp <= set_cmp | (flags.cmp & ~clr_cmp);
         flags.ovf <= set_ovf | (flags.ovf & ~clr_ovf);
         if (rd_flags) begin
            armed <= flags;
         end else begin
            if (rd_cap_lo)
               armed.cap <= 1'b0;
            if (rd_cmp_lo)
               armed.cmp <= 1'b0;
            if (rd_cnt_lo)
               armed.ovf <= 1'b0;
         end
      end
   end
endmodule : tcs_timer
`default_nettype wire

// *** bench/tcs_timer_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module tcs_timer_monitor
   import tcs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire tcs_bus_s bus,
   input wire logic stop_mode,
   input wire logic capture_pin,
   input wire logic [7:0] rdata,
   input wire logic compare_pin,
   input wire logic irq,
   input wire logic [15:0] count
);
   wire logic [7:0] count_hi = count[15:8];
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_count_step: assert property ($changed(count) |-> count == $past(count) + 16'h1)
      else $error("counter skipped a value");
   a_count_pace: assert property ($changed(count) |=> $stable(count)[*3])
      else $error("counter stepped early");
   a_stop_freeze: assert property (stop_mode |=> $stable(count))
      else $error("counter moved while stopped");
   a_flags_low: assert property (bus.rd && bus.addr == 8'h13 |=> rdata[4:0] == 5'h00)
      else $error("flag low bits not zero");
   a_count_read: assert property (bus.rd && bus.addr == 8'h18 |=> rdata == $past(count_hi))
      else $error("counter high read wrong");
   a_alt_read: assert property (bus.rd && bus.addr == 8'h1A |=> rdata == $past(count_hi))
      else $error("alternate high read wrong");
   a_unmapped_zero: assert property (bus.rd && bus.addr == 8'h00 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!bus.rd |=> $stable(rdata))
      else $error("read data moved without a read");
   c_irq: cover property ($rose(irq));
   c_pin: cover property ($changed(compare_pin));
   c_cap_low: cover property (bus.rd && bus.addr == 8'h15);
endmodule : tcs_timer_monitor
`default_nettype wire

// *** bench/tcs_cap_src.sv ***
`timescale 1ns/10ps
`default_nettype none
module tcs_cap_src (
   output logic capture_pin
);
   // edges are placed between bus clock edges, as an unrelated source would
   initial capture_pin = 1'b0;
   task automatic move(input logic x);
      capture_pin = x;
   endtask : move
endmodule : tcs_cap_src
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import tcs_pkg::*;
;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic stop_mode = 1'b0;
   tcs_bus_s bus = '0;
   wire logic capture_pin;
   logic [7:0] rdata;
   logic compare_pin;
   logic irq;
   logic [15:0] count;
   logic [7:0] d;
   logic [15:0] v;
   int fails = 0;
   int comparisons = 0;
   always #4 mclk = ~mclk;
   tcs_cap_src i_src (.capture_pin(capture_pin));
   tcs_timer i_dut (.mclk(mclk), .rst(rst), .bus(bus), .stop_mode(stop_mode), .capture_pin(capture_pin),
      .rdata(rdata), .compare_pin(compare_pin), .irq(irq), .count(count));
   task automatic print_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      cyc(1);
      bus = '{1'b0, 1'b1, a, x};
      cyc(1);
      bus.wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      cyc(1);
      bus = '{1'b1, 1'b0, a, 8'h00};
      cyc(1);
      bus.rd = 1'b0;
      d = rdata;
   endtask : rd
   task automatic wait_pin(input logic x);
      int i;
      for (i = 0; i < 300 && compare_pin !== x; i++) cyc(1);
      chk("compare_pin", {15'h0, x}, {15'h0, compare_pin});
      if (compare_pin !== x) print_verdict();
   endtask : wait_pin
   task automatic t_reset();
      wr(8'h19, 8'h00);
      rd(8'h18);
      chk("count high", 16'h00FF, {8'h00, d});
      rd(8'h12);
      chk("control", 16'h0000, {8'h00, d});
      rd(8'h00);
      chk("unmapped", 16'h0000, {8'h00, d});
      $display("done reset");
   endtask : t_reset
   task automatic t_overflow();
      int i;
      for (i = 0; i < 40 && count !== 16'h0001; i++) cyc(1);
      chk("count wrap", 16'h0001, count);
      rd(8'h13);
      chk("flags", 16'h0020, {10'h0, d[5:0]});
      rd(8'h1B);
      rd(8'h13);
      chk("overflow kept", 16'h0020, {10'h0, d[5:0]});
      rd(8'h19);
      rd(8'h13);
      chk("overflow cleared", 16'h0000, {10'h0, d[5:0]});
      $display("done overflow");
   endtask : t_overflow
   task automatic t_compare();
      wr(8'h12, 8'h41);
      v = count + 16'd12;
      wr(8'h16, v[15:8]);
      rd(8'h13);
      wr(8'h17, v[7:0]);
      wait_pin(1'b1);
      cyc(4);
      chk("compare irq", 16'h0001, {15'h0, irq});
      rd(8'h13);
      chk("compare flag", 16'h0040, {8'h00, d & 8'h40});
      rd(8'h17);
      chk("compare low", {8'h00, v[7:0]}, {8'h00, d});
      rd(8'h13);
      chk("compare cleared", 16'h0000, {8'h00, d & 8'h40});
      chk("irq off", 16'h0000, {15'h0, irq});
      wr(8'h12, 8'h40);
      v = count + 16'd40;
      wr(8'h16, v[15:8]);
      cyc(200);
      chk("pin held", 16'h0001, {15'h0, compare_pin});
      v = count + 16'd8;
      wr(8'h16, v[15:8]);
      rd(8'h16);
      chk("compare high", {8'h00, v[15:8]}, {8'h00, d});
      wr(8'h17, v[7:0]);
      wait_pin(1'b0);
      $display("done compare");
   endtask : t_compare
   task automatic t_capture();
      wr(8'h12, 8'h82);
      rd(8'h15);
      i_src.move(1'b1);
      v = count + 16'h1;
      cyc(12);
      chk("capture irq", 16'h0001, {15'h0, irq});
      rd(8'h13);
      chk("capture flag", 16'h0080, {8'h00, d & 8'h80});
      rd(8'h14);
      chk("capture high", {8'h00, v[15:8]}, {8'h00, d});
      rd(8'h15);
      chk("capture low", {8'h00, v[7:0]}, {8'h00, d});
      rd(8'h13);
      chk("capture cleared", 16'h0000, {8'h00, d & 8'h80});
      rd(8'h14);
      i_src.move(1'b0);
      cyc(8);
      i_src.move(1'b1);
      cyc(12);
      rd(8'h15);
      chk("capture blocked", {8'h00, v[7:0]}, {8'h00, d});
      wr(8'h12, 8'h80);
      i_src.move(1'b0);
      v = count + 16'h1;
      cyc(12);
      rd(8'h14);
      chk("falling high", {8'h00, v[15:8]}, {8'h00, d});
      rd(8'h15);
      chk("falling low", {8'h00, v[7:0]}, {8'h00, d});
      $display("done capture");
   endtask : t_capture
   task automatic t_stop();
      stop_mode = 1'b1;
      v = count;
      cyc(10);
      chk("stopped count", v, count);
      stop_mode = 1'b0;
      $display("done stop");
   endtask : t_stop
   initial begin
      cyc(3);
      rst = 1'b0;
      t_reset();
      t_overflow();
      t_compare();
      t_capture();
      t_stop();
      print_verdict();
   end
endmodule : tb_top
bind tcs_timer tcs_timer_monitor i_mon (.mclk(mclk), .rst(rst), .bus(bus), .stop_mode(stop_mode),
   .capture_pin(capture_pin), .rdata(rdata), .compare_pin(compare_pin), .irq(irq), .count(count));
`default_nettype wire
